// file: hw/uart_pkg.sv
package uart_pkg;
  localparam int CLK_HZ          = 50_000_000;
  localparam int BAUD_MIN        = 1200;
  localparam int BAUD_MAX        = 3_000_000;
  localparam int DIV_W           = 16;
  localparam int DATA_BITS       = 8;
  localparam int BIT_CNT_W       = 4;
  localparam int OVS             = 16;
  localparam int OVS_W           = 4;
  localparam int OVS_MID         = 7;
  localparam int BRK_W           = 32;
  localparam int DIV_MAX_1200    = CLK_HZ / (BAUD_MIN * OVS);
  localparam logic [DIV_W-1:0] DIV_RESET = 16'h00A3;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD  = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [BRK_W-1:0] BRK_TIMEOUT_RESET = 32'h000001A4;
  localparam int RX_FIFO_DEPTH   = 4;
endpackage

// file: hw/char_store.sv
module char_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  output logic      [WIDTH-1:0] rd_data,
  output logic                  empty,
  output logic                  full
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
  logic [WIDTH-1:0] rd_q, rd_d;
  logic             do_wr, do_rd;

  assign empty = (wp_q == rp_q);
  assign full  = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  assign rd_data = rd_q;

  always_comb begin
    do_wr = wr_en && !full;
    do_rd = rd_en && !empty;
    wp_d  = wp_q + {{AW{1'b0}}, do_wr};
    rp_d  = rp_q + {{AW{1'b0}}, do_rd};
    rd_d  = do_rd ? mem[rp_q[AW-1:0]] : rd_q;
  end

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wp_q[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
      rd_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      rd_q <= rd_d;
    end
  end
endmodule

// file: hw/uart_with_break_reset.sv
//Contract
// - one receive and one transmit line, optional low-active rts and cts flow control.
// - device drives rts_b out low-active and samples cts_b in low-active.
// - baud divisor programmable from 1200 baud to 3.0 Mbaud within stated error; code tops out at 1.5625 Mbaud (divisor 1 at 16x oversampling, 50 MHz).
// - 8 data bits, optional odd or even parity, 1 or 2 stop bits.
// - receiver detects continuous low on rx and measures its length.
// - break longer than persistent timeout causes a device reset request; code raises it only while port_enable is high.
// - transmitter can hold tx low to send a break and wake host.
// - reset comes from pin, power-on, long break, or watchdog.
// - in reset, bidirectional pins are inputs and outputs are tri-stated.
// - in reset, rx and cts pulled low weakly, tx and rts high weakly.
// - warm reset keeps data rate; cold reset restores default rate.
// - flow control selectable between rts/cts and none.
module uart_with_break_reset #(
  parameter int                            DIV_W   = uart_pkg::DIV_W,
  parameter int                            BRK_W   = uart_pkg::BRK_W,
  parameter logic [uart_pkg::BRK_W-1:0]    BRK_TMO = uart_pkg::BRK_TIMEOUT_RESET
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             cold_rst_b,
  input  wire logic             pin_rst,
  input  wire logic             por,
  input  wire logic             wdog_expire,
  input  wire logic             port_enable,
  input  wire logic             rate_load,
  input  wire logic [DIV_W-1:0] rate_div,
  input  wire logic [1:0]       parity_sel,
  input  wire logic             two_stop,
  input  wire logic             flow_en,
  input  wire logic [BRK_W-1:0] break_reset_timeout,
  input  wire logic             rx_pin,
  input  wire logic             cts_b_pin,
  output logic                  tx_o,
  output logic                  tx_oe,
  output logic                  rts_b_o,
  output logic                  rts_b_oe,
  input  wire logic             tx_valid,
  input  wire logic [7:0]       tx_data,
  output logic                  tx_ready,
  input  wire logic             tx_break,
  output logic                  rx_valid,
  output logic [7:0]            rx_data,
  input  wire logic             rx_ready,
  output logic                  rx_parity_err,
  output logic                  rx_frame_err,
  output logic                  break_active,
  output logic [BRK_W-1:0]      break_duration,
  output logic                  sys_reset_req,
  output logic                  pull_up_tx_rts,
  output logic                  pull_dn_rx_cts
);
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_STOP = 5'h08, TX_BRK = 5'h10
  } tx_state_t;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
  } rx_state_t;

  logic             rx_m_q, rx_s_q, cts_m_q, cts_s_q;
  logic [DIV_W-1:0] div_q, div_d, dcnt_q, dcnt_d;
  logic             tick;
  logic             in_rst;
  tx_state_t        ts_q, ts_d;
  rx_state_t        rs_q, rs_d;
  logic [3:0]       tov_q, tov_d, rov_q, rov_d;
  logic [3:0]       tbit_q, tbit_d, rbit_q, rbit_d;
  logic [7:0]       tsh_q, tsh_d, rsh_q, rsh_d;
  logic             tpar_q, tpar_d, tline_q, tline_d, tstop2_q, tstop2_d;
  logic             rperr_q, rperr_d, rferr_q, rferr_d, rpar_q, rpar_d;
  logic [BRK_W-1:0] bcnt_q, bcnt_d;
  logic             brst_q, brst_d;
  logic             st_wr, st_rd, st_empty, st_full, rv_q, rv_d;
  logic             sample;
  logic [DIV_W-1:0] tdcnt_q, tdcnt_d;
  logic             ttick;

  assign in_rst        = !rst_b || pin_rst || por || wdog_expire || brst_q;
  assign sys_reset_req = pin_rst || por || wdog_expire || brst_q;
  assign tx_oe    = !in_rst && port_enable;
  assign rts_b_oe = !in_rst && port_enable;
  assign pull_up_tx_rts = in_rst;
  assign pull_dn_rx_cts = in_rst;
  assign tx_o      = tline_q;
  assign rts_b_o   = flow_en ? st_full : 1'b0;
  assign tick      = (dcnt_q == '0);
  assign ttick     = (tdcnt_q == '0);
  assign sample    = tick && (rov_q == uart_pkg::OVS_MID[3:0]);
  assign break_active   = (bcnt_q != '0);
  assign break_duration = bcnt_q;
  assign tx_ready  = (ts_q == TX_IDLE) && !tx_break && (!flow_en || !cts_s_q);
  assign rx_valid  = rv_q;
  assign st_rd     = !st_empty && (!rv_q || rx_ready);
  assign rx_parity_err = rperr_q;
  assign rx_frame_err  = rferr_q;

  char_store #(.WIDTH(8), .DEPTH(uart_pkg::RX_FIFO_DEPTH), .AW(2)) u_store (
    .clk     (clk),
    .rst_b   (rst_b),
    .wr_en   (st_wr),
    .wr_data (rsh_q),
    .rd_en   (st_rd),
    .rd_data (rx_data),
    .empty   (st_empty),
    .full    (st_full)
  );

  always_comb begin
    rv_d = rv_q;
    if (st_rd) begin
      rv_d = 1'b1;
    end else if (rx_ready) begin
      rv_d = 1'b0;
    end
  end

  always_comb begin
    div_d  = (rate_load && rate_div != '0) ? rate_div : div_q;
    dcnt_d = tick ? div_q : dcnt_q - 1'b1;
    // tx bit phase restarts with each character
    tdcnt_d = (ts_q == TX_IDLE || ttick) ? div_q : tdcnt_q - 1'b1;
  end

  always_comb begin
    ts_d = ts_q; tov_d = tov_q; tbit_d = tbit_q; tsh_d = tsh_q;
    tpar_d = tpar_q; tline_d = tline_q; tstop2_d = tstop2_q;
    unique case (ts_q)
      TX_IDLE: begin
        tline_d = 1'b1;
        if (tx_break) begin
          ts_d = TX_BRK;
        end else if (tx_valid && tx_ready) begin
          ts_d = TX_START; tsh_d = tx_data; tov_d = '0; tbit_d = '0;
          tpar_d = (parity_sel == uart_pkg::PAR_ODD) ? ~^tx_data : ^tx_data;
          tstop2_d = two_stop;
        end
      end
      TX_BRK: begin
        tline_d = 1'b0;
        if (!tx_break) begin
          ts_d = TX_IDLE;
          tline_d = 1'b1;
        end
      end
      TX_START: begin
        tline_d = 1'b0;
        if (ttick) begin
          tov_d = tov_q + 1'b1;
          if (tov_q == 4'hF) begin
            ts_d = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        if (tbit_q < 4'h8) begin
          tline_d = tsh_q[tbit_q[2:0]];
        end else begin
          tline_d = tpar_q;
        end
        if (ttick) begin
          tov_d = tov_q + 1'b1;
          if (tov_q == 4'hF) begin
            tbit_d = tbit_q + 1'b1;
            if (tbit_q == 4'h8 || (tbit_q == 4'h7 && parity_sel == uart_pkg::PAR_NONE)) begin
              ts_d = TX_STOP;
            end
          end
        end
      end
      TX_STOP: begin
        tline_d = 1'b1;
        if (ttick) begin
          tov_d = tov_q + 1'b1;
          if (tov_q == 4'hF) begin
            if (tstop2_q) begin
              tstop2_d = 1'b0;
            end else begin
              ts_d = TX_IDLE;
            end
          end
        end
      end
      default: ts_d = TX_IDLE;
    endcase
  end

  always_comb begin
    rs_d = rs_q; rov_d = rov_q; rbit_d = rbit_q; rsh_d = rsh_q; rpar_d = rpar_q;
    rperr_d = rperr_q; rferr_d = rferr_q; st_wr = 1'b0;
    if (tick && rs_q != RX_IDLE) begin
      rov_d = rov_q + 1'b1;
    end
    unique case (rs_q)
      RX_IDLE: if (!rx_s_q && bcnt_q == '0) begin
        rs_d = RX_START; rov_d = '0;
      end
      RX_START: if (sample) begin
        rs_d = rx_s_q ? RX_IDLE : RX_DATA; rbit_d = '0;
      end
      RX_DATA: if (sample) begin
        rsh_d = {rx_s_q, rsh_q[7:1]};
        rbit_d = rbit_q + 1'b1;
        if (rbit_q == 4'h7) begin
          rs_d = (parity_sel == uart_pkg::PAR_NONE) ? RX_STOP : RX_PAR;
        end
      end
      RX_PAR: if (sample) begin
        rpar_d = rx_s_q; rs_d = RX_STOP;
      end
      RX_STOP: if (sample) begin
        rs_d = RX_IDLE;
        rferr_d = !rx_s_q;
        rperr_d = (parity_sel == uart_pkg::PAR_ODD)  ? (rpar_q == ^rsh_q) :
                  (parity_sel == uart_pkg::PAR_EVEN) ? (rpar_q != ^rsh_q) : 1'b0;
        st_wr = rx_s_q;
      end
      default: rs_d = RX_IDLE;
    endcase
  end

  always_comb begin
    bcnt_d = rx_s_q ? '0 : ((&bcnt_q) ? bcnt_q : bcnt_q + 1'b1);
    brst_d = (bcnt_q > break_reset_timeout) && port_enable;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_m_q <= 1'b1; rx_s_q <= 1'b1; cts_m_q <= 1'b1; cts_s_q <= 1'b1;
    end else begin
      rx_m_q <= rx_pin; rx_s_q <= rx_m_q; cts_m_q <= cts_b_pin; cts_s_q <= cts_m_q;
    end
  end

  always_ff @(posedge clk or negedge cold_rst_b) begin
    if (!cold_rst_b) begin
      div_q <= uart_pkg::DIV_RESET;
    end else begin
      div_q <= div_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dcnt_q <= '0; ts_q <= TX_IDLE; rs_q <= RX_IDLE; tov_q <= '0; rov_q <= '0;
      tbit_q <= '0; rbit_q <= '0; tsh_q <= '0; rsh_q <= '0; tpar_q <= 1'b0;
      tline_q <= 1'b1; tstop2_q <= 1'b0; rperr_q <= 1'b0; rferr_q <= 1'b0;
      rpar_q <= 1'b0; bcnt_q <= '0; brst_q <= 1'b0; rv_q <= 1'b0;
      tdcnt_q <= '0;
    end else begin
      dcnt_q <= dcnt_d; ts_q <= ts_d; rs_q <= rs_d; tov_q <= tov_d; rov_q <= rov_d;
      tbit_q <= tbit_d; rbit_q <= rbit_d; tsh_q <= tsh_d; rsh_q <= rsh_d; tpar_q <= tpar_d;
      tline_q <= tline_d; tstop2_q <= tstop2_d; rperr_q <= rperr_d; rferr_q <= rferr_d;
      rpar_q <= rpar_d; bcnt_q <= bcnt_d; brst_q <= brst_d; rv_q <= rv_d;
      tdcnt_q <= tdcnt_d;
    end
  end
endmodule

// file: test/uart_monitor.sv
module uart_monitor #(
  parameter int BRK_W = 32
) (
  input wire logic             clk,
  input wire logic             rst_b,
  input wire logic             pin_rst,
  input wire logic             por,
  input wire logic             wdog_expire,
  input wire logic             port_enable,
  input wire logic             flow_en,
  input wire logic [BRK_W-1:0] break_reset_timeout,
  input wire logic             rx_pin,
  input wire logic             cts_b_pin,
  input wire logic             tx_o,
  input wire logic             tx_oe,
  input wire logic             rts_b_o,
  input wire logic             rts_b_oe,
  input wire logic             tx_valid,
  input wire logic             tx_ready,
  input wire logic             break_active,
  input wire logic [BRK_W-1:0] break_duration,
  input wire logic             sys_reset_req,
  input wire logic             pull_up_tx_rts,
  input wire logic             pull_dn_rx_cts
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RST_PINS:
    assert property (disable iff (1'b0) !rst_b |-> !tx_oe && !rts_b_oe && pull_up_tx_rts
      && pull_dn_rx_cts) else $error("pins active in reset");
  AST_SRC_REQ:
    assert property ($rose(pin_rst || por || wdog_expire) |-> ##[0:2] sys_reset_req && !tx_oe)
    else $error("reset source ignored");
  AST_BRK_REQ:
    assert property (port_enable && break_active && break_duration > break_reset_timeout
      |-> ##[0:2] sys_reset_req) else $error("long break ignored");
  AST_BRK_SEEN:
    assert property (!rx_pin [*4] |-> break_active) else $error("low rx not seen");
  AST_BRK_CNT:
    assert property (break_active && $past(break_active) |-> break_duration ==
      $past(break_duration) + 1'b1) else $error("break length not counted");
  AST_TX_START:
    assert property (tx_valid && tx_ready |-> ##2 !tx_o) else $error("no start bit");
  AST_TX_IDLE:
    assert property (tx_ready |-> tx_o) else $error("idle line not high");
  AST_CTS_HOLD:
    assert property ((flow_en && cts_b_pin) [*4] |-> !tx_ready) else $error("cts ignored");
  AST_RTS_OFF:
    assert property (!flow_en [*2] |-> !rts_b_o) else $error("rts high without flow");
  cover property (tx_valid && tx_ready);
  cover property (sys_reset_req && break_active);
  cover property (flow_en && rts_b_o);
endmodule

bind uart_with_break_reset uart_monitor #(.BRK_W(BRK_W)) uart_monitor_inst (.*);

// file: test/uart_host_model.sv
module uart_host_model #(
  parameter int BIT = 32
) (
  input  wire logic clk,
  output logic      rx_pin,
  output logic      cts_b_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_pin = 1'b1;
    cts_b_pin = 1'b0;
  end
  task automatic line(input logic v, input int k);
    rx_pin = v;
    repeat (k) @(negedge clk);
  endtask
  task automatic send(input logic [7:0] b, input logic [1:0] p, input logic [1:0] err);
    line(1'b0, BIT);
    for (int i = 0; i < 8; i++) line(b[i], BIT);
    if (p != uart_pkg::PAR_NONE) line(^b ^ (p == uart_pkg::PAR_ODD) ^ err[0], BIT);
    line(!err[1], BIT);
    line(1'b1, 2 * BIT);
  endtask
endmodule

// file: test/uart_with_break_reset_tb_top.sv
module uart_with_break_reset_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] DIV = 16'h0001;
  localparam int          BIT = (DIV + 1) * uart_pkg::OVS;
  logic        clk, rst_b, cold_rst_b, pin_rst, por, wdog_expire, port_enable, rate_load;
  logic        two_stop, flow_en, rx_pin, cts_b_pin, tx_o, tx_oe, rts_b_o, rts_b_oe;
  logic        tx_valid, tx_ready, tx_break, rx_valid, rx_ready, rx_parity_err;
  logic        rx_frame_err, break_active, sys_reset_req, pull_up_tx_rts, pull_dn_rx_cts;
  logic [1:0]  parity_sel;
  logic [7:0]  tx_data, rx_data, b;
  logic [7:0]  q [5];
  logic [15:0] rate_div;
  logic [31:0] break_reset_timeout, break_duration;
  int          seed = 12962, mismatches = 0, compares = 0, cycles = 0, n;
  uart_with_break_reset uart_with_break_reset_inst (.*);
  uart_host_model #(.BIT(BIT)) uart_host_model_inst (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  function automatic logic pbit(input logic [7:0] d, input logic [1:0] p);
    return ^d ^ (p == uart_pkg::PAR_ODD);
  endfunction
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic take(input logic [7:0] d);
    tx_data = d;
    tx_valid = 1'b1;
    n = 0;
    while (tx_ready !== 1'b1 && n++ < 200) tick(1);
    tick(1);
    tx_valid = 1'b0;
  endtask
  task automatic tx_char(input logic [7:0] d);
    take(d);
    tick(BIT / 2 - 1);
    chk("tx_start", tx_o, 1'b0);
    for (int i = 0; i < 8; i++) begin
      tick(BIT);
      chk("tx_bit", tx_o, d[i]);
    end
    if (parity_sel != uart_pkg::PAR_NONE) begin
      tick(BIT);
      chk("tx_parity", tx_o, pbit(d, parity_sel));
    end
    tick(BIT);
    chk("tx_stop", tx_o, 1'b1);
    tick(BIT);
    chk("tx_second_stop", tx_ready, !two_stop);
    tick(BIT);
  endtask
  task automatic rx_get(input logic [7:0] e, input logic pe, input logic fe);
    n = 0;
    while (rx_valid !== 1'b1 && !fe && n++ < 400) tick(1);
    // bad stop bit: char dropped, not stored
    chk("rx_valid", rx_valid, !fe);
    if (!fe) chk("rx_data", rx_data, e);
    chk("rx_parity_err", rx_parity_err, pe);
    chk("rx_frame_err", rx_frame_err, fe);
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
  endtask
  initial begin
    {rst_b, cold_rst_b, pin_rst, por, wdog_expire, rate_load, two_stop, flow_en} = 8'h00;
    {tx_valid, tx_break, rx_ready, parity_sel, tx_data} = 13'h0000;
    port_enable = 1'b1;
    rate_div = DIV;
    break_reset_timeout = 32'h00010000;
    tick(3);
    chk("reset_pins", {tx_oe, rts_b_oe, pull_up_tx_rts, pull_dn_rx_cts}, 4'h3);
    {rst_b, cold_rst_b} = 2'h3;
    tick(1);
    rate_load = 1'b1;
    tick(1);
    rate_load = 1'b0;
    chk("pins_driven", {tx_oe, rts_b_oe, tx_o}, 3'h7);
    for (int k = 0; k < 6; k++) begin
      parity_sel = 2'(k % 3);
      two_stop = (k > 2);
      tx_char(k == 0 ? 8'h80 : 8'($random(seed)));
    end
    for (int k = 0; k < 5; k++) begin
      parity_sel = 2'(k % 3);
      b = 8'($random(seed));
      uart_host_model_inst.send(b, parity_sel, {k == 3, k == 4});
      rx_get(b, k == 4, k == 3);
    end
    flow_en = 1'b1;
    uart_host_model_inst.cts_b_pin = 1'b1;
    tick(4);
    chk("cts_block", tx_ready, 1'b0);
    // four in the store plus one in the output register
    for (int k = 0; k < 5; k++) begin
      q[k] = 8'($random(seed));
      uart_host_model_inst.send(q[k], parity_sel, 2'h0);
    end
    chk("rts_full", {rts_b_o, rts_b_oe}, 2'h3);
    for (int k = 0; k < 5; k++) rx_get(q[k], 1'b0, 1'b0);
    tick(2);
    chk("rts_free", rts_b_o, 1'b0);
    uart_host_model_inst.cts_b_pin = 1'b0;
    flow_en = 1'b0;
    tx_break = 1'b1;
    tick(4);
    chk("tx_break", tx_o, 1'b0);
    tx_break = 1'b0;
    tick(BIT);
    chk("tx_after_break", tx_o, 1'b1);
    break_reset_timeout = 32'h00000064;
    uart_host_model_inst.line(1'b0, 60);
    chk("short_break", {break_active, sys_reset_req}, 2'h2);
    uart_host_model_inst.line(1'b1, 8);
    uart_host_model_inst.line(1'b0, 130);
    chk("long_break", {break_active, sys_reset_req}, 2'h3);
    chk("break_len", break_duration > 32'h00000064, 1'b1);
    uart_host_model_inst.line(1'b1, 4 * BIT);
    for (int k = 0; k < 3; k++) begin
      {wdog_expire, por, pin_rst} = 3'(1 << k);
      tick(3);
      chk("source_reset", {sys_reset_req, tx_oe}, 2'h2);
      {wdog_expire, por, pin_rst} = 3'h0;
      tick(3);
    end
    for (int k = 0; k < 2; k++) begin
      rst_b = 1'b0;
      cold_rst_b = (k == 0);
      tick(1);
      {rst_b, cold_rst_b} = 2'h3;
      tick(2);
      take(8'hFF);
      tick(1);
      n = 0;
      while (tx_o === 1'b0 && n < 5000) begin
        tick(1);
        n++;
      end
      chk("bit_len", n, k ? (uart_pkg::DIV_RESET + 1) * uart_pkg::OVS : BIT);
      tick(BIT * 12);
    end
    end_sim();
  end
endmodule
